// ### inc/ppp_pkg.sv
// Shared constants for the primary PCI port signalling block.
// Assumes a single PCI clock domain and a synchronous active-low reset.
//
// How it works
// - Sustained lines driven high one clock before release
// - Address sampled in first frame-asserted clock
// - Data valid while the driving ready is asserted
// - Command in address phase, byte enables after
// - Even parity across data, command and parity
// - Write parity checked one clock after ready
// - Read parity driven one clock after target ready
// - Parity released one clock after data lines
// - Frame deasserted marks final data phase
// - Asserted ready held until phase completes
package ppp_pkg;
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam logic [31:0] AD_RST = 32'h0000_0000;
    localparam logic [3:0] CBE_RST = 4'h0;
    localparam logic [3:0] CMD_PARK = 4'h0;
    // Frame, both readies, grant and parity all idle high out of reset
    localparam logic [4:0] CTL_RST = 5'h1F;

    typedef enum logic [3:0] {
        PPP_IDLE = 4'b0001,
        PPP_ADDR = 4'b0010,
        PPP_DATA = 4'b0100,
        PPP_TURN = 4'b1000
    } ppp_state_t;
endpackage

// ### rtl/ppp_sync2.sv
// Two-flop synchroniser for pins that enter from the PCI bus.
// Assumes the pins are sampled on sys_clk; first flop feeds only the second.
`timescale 1ns/1ps
module ppp_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] out_next;

    always_comb begin
        meta_next = din;
        out_next = meta_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_reg <= RST;
            dout <= RST;
        end else begin
            meta_reg <= meta_next;
            dout <= out_next;
        end
    end
endmodule

// ### rtl/ppp_port.sv
// Primary PCI port signalling as the target side of the bridge.
// Assumes an external initiator; the bridge core supplies read data and
// decides when to assert target ready. Pins are synchronised by two flops.
`timescale 1ns/1ps
module ppp_port (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe,
    input wire logic [3:0] primary_cmd_byte_en_lines_in,
    output logic [3:0] primary_cmd_byte_en_lines_out,
    output logic primary_cmd_byte_en_lines_oe,
    input wire logic primary_parity_line_in,
    output logic primary_parity_line_out,
    output logic primary_parity_line_oe,
    input wire logic frame_n_in,
    input wire logic primary_initiator_ready_n_in,
    input wire logic primary_target_ready_n_in,
    output logic primary_target_ready_n_out,
    output logic primary_target_ready_n_oe,
    input wire logic grant_n,
    input wire logic core_claim,
    input wire logic core_ready,
    input wire logic [31:0] core_rd_data,
    output logic [31:0] addr_captured,
    output logic [3:0] cmd_captured,
    output logic addr_valid,
    output logic [31:0] wr_data,
    output logic [3:0] wr_byte_en,
    output logic xfer_done,
    output logic last_phase,
    output logic addr_par_err,
    output logic data_par_err
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [31:0] ad_s;
    logic [3:0] cbe_s;
    logic [4:0] ctl_s;
    logic frame_s, irdy_s, trdy_s, gnt_s, par_s;

    ppp_sync2 #(.W(32), .RST(ppp_pkg::AD_RST)) u_ad (
        .sys_clk(sys_clk), .resetn(resetn), .din(ad_in), .dout(ad_s));
    ppp_sync2 #(.W(4), .RST(ppp_pkg::CBE_RST)) u_cbe (
        .sys_clk(sys_clk), .resetn(resetn),
        .din(primary_cmd_byte_en_lines_in), .dout(cbe_s));
    ppp_sync2 #(.W(5), .RST(ppp_pkg::CTL_RST)) u_ctl (
        .sys_clk(sys_clk), .resetn(resetn),
        .din({frame_n_in, primary_initiator_ready_n_in, primary_target_ready_n_in,
              grant_n, primary_parity_line_in}),
        .dout(ctl_s));
    assign frame_s = ctl_s[4];
    assign irdy_s = ctl_s[3];
    assign trdy_s = ctl_s[2];
    assign gnt_s = ctl_s[1];
    assign par_s = ctl_s[0];

    // ------------------------------------------------------------
    // Phase tracking and driving state
    // ------------------------------------------------------------
    ppp_pkg::ppp_state_t st_reg, st_next;
    logic frame_d_reg, frame_d_next;
    logic is_read_reg, is_read_next;
    logic chk_a_reg, chk_a_next, chk_w_reg, chk_w_next;
    logic [31:0] ad_out_next, addr_next, wr_data_next;
    logic [3:0] cbe_out_next, cmd_next, be_next;
    logic ad_oe_next, cbe_oe_next, par_oe_next, par_out_next;
    logic trdy_out_next, trdy_oe_next;
    logic avalid_next, done_next, last_next, aerr_next, derr_next;
    logic [36:0] chk_word_reg, chk_word_next;
    logic [3:0] par_cbe;
    logic parked;
    logic fire;

    assign parked = (st_reg == ppp_pkg::PPP_IDLE) && frame_s && irdy_s && !gnt_s;
    assign fire = !irdy_s && !trdy_s;

    always_comb begin
        st_next = st_reg;
        frame_d_next = frame_s;
        is_read_next = is_read_reg;
        addr_next = addr_captured;
        cmd_next = cmd_captured;
        wr_data_next = wr_data;
        be_next = wr_byte_en;
        avalid_next = 1'b0;
        done_next = 1'b0;
        last_next = 1'b0;
        chk_a_next = 1'b0;
        chk_w_next = 1'b0;
        chk_word_next = chk_word_reg;
        aerr_next = 1'b0;
        derr_next = 1'b0;
        ad_out_next = ad_out;
        cbe_out_next = primary_cmd_byte_en_lines_out;
        ad_oe_next = 1'b0;
        cbe_oe_next = 1'b0;
        // Parity follows data by one clock, so its enable lags too
        par_oe_next = ad_oe;
        // On reads the byte enables come from the initiator, so cover its copy
        par_cbe = primary_cmd_byte_en_lines_oe ? primary_cmd_byte_en_lines_out : cbe_s;
        par_out_next = ^{ad_out, par_cbe};
        trdy_out_next = 1'b1;
        trdy_oe_next = 1'b0;
        // Parity sampled the clock after the address or write word
        if (chk_a_reg)
            aerr_next = ^{chk_word_reg[35:0], par_s};
        if (chk_w_reg)
            derr_next = ^{chk_word_reg[35:0], par_s};
        case (st_reg)
            ppp_pkg::PPP_IDLE: begin
                if (parked) begin
                    // Park: drive stable levels so the lines never float
                    ad_oe_next = 1'b1;
                    cbe_oe_next = 1'b1;
                    ad_out_next = ppp_pkg::AD_RST;
                    cbe_out_next = ppp_pkg::CMD_PARK;
                end
                if (!frame_s && frame_d_reg) begin
                    addr_next = ad_s;
                    cmd_next = cbe_s;
                    is_read_next = !cbe_s[0];
                    chk_word_next = {1'b0, ad_s, cbe_s};
                    chk_a_next = 1'b1;
                    st_next = ppp_pkg::PPP_ADDR;
                end
            end
            ppp_pkg::PPP_ADDR: begin
                avalid_next = 1'b1;
                st_next = core_claim ? ppp_pkg::PPP_DATA : ppp_pkg::PPP_IDLE;
            end
            ppp_pkg::PPP_DATA: begin
                trdy_oe_next = 1'b1;
                ad_oe_next = is_read_reg;
                // Ready stays low once given, until the word moves
                trdy_out_next = !(core_ready || !primary_target_ready_n_out);
                if (is_read_reg && (core_ready && primary_target_ready_n_out))
                    ad_out_next = core_rd_data;
                if (fire) begin
                    // A word only moves with both readies low
                    done_next = 1'b1;
                    trdy_out_next = 1'b1;
                    if (!is_read_reg) begin
                        wr_data_next = ad_s;
                        be_next = cbe_s;
                        chk_word_next = {1'b0, ad_s, cbe_s};
                        chk_w_next = 1'b1;
                    end
                    if (frame_s) begin
                        last_next = 1'b1;
                        ad_oe_next = 1'b0;
                        st_next = ppp_pkg::PPP_TURN;
                    end
                end
            end
            ppp_pkg::PPP_TURN: begin
                // Ready was driven high at the final word; float it now
                trdy_out_next = 1'b1;
                st_next = ppp_pkg::PPP_IDLE;
            end
            default: st_next = ppp_pkg::PPP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_reg <= ppp_pkg::PPP_IDLE;
            frame_d_reg <= 1'b1;
            is_read_reg <= 1'b0;
            chk_a_reg <= 1'b0;
            chk_w_reg <= 1'b0;
            chk_word_reg <= '0;
            ad_out <= ppp_pkg::AD_RST;
            ad_oe <= 1'b0;
            primary_cmd_byte_en_lines_out <= ppp_pkg::CBE_RST;
            primary_cmd_byte_en_lines_oe <= 1'b0;
            primary_parity_line_out <= 1'b0;
            primary_parity_line_oe <= 1'b0;
            primary_target_ready_n_out <= 1'b1;
            primary_target_ready_n_oe <= 1'b0;
            addr_captured <= ppp_pkg::AD_RST;
            cmd_captured <= ppp_pkg::CBE_RST;
            addr_valid <= 1'b0;
            wr_data <= ppp_pkg::AD_RST;
            wr_byte_en <= ppp_pkg::CBE_RST;
            xfer_done <= 1'b0;
            last_phase <= 1'b0;
            addr_par_err <= 1'b0;
            data_par_err <= 1'b0;
        end else begin
            st_reg <= st_next;
            frame_d_reg <= frame_d_next;
            is_read_reg <= is_read_next;
            chk_a_reg <= chk_a_next;
            chk_w_reg <= chk_w_next;
            chk_word_reg <= chk_word_next;
            ad_out <= ad_out_next;
            ad_oe <= ad_oe_next;
            primary_cmd_byte_en_lines_out <= cbe_out_next;
            primary_cmd_byte_en_lines_oe <= cbe_oe_next;
            primary_parity_line_out <= par_out_next;
            primary_parity_line_oe <= par_oe_next;
            primary_target_ready_n_out <= trdy_out_next;
            primary_target_ready_n_oe <= trdy_oe_next;
            addr_captured <= addr_next;
            cmd_captured <= cmd_next;
            addr_valid <= avalid_next;
            wr_data <= wr_data_next;
            wr_byte_en <= be_next;
            xfer_done <= done_next;
            last_phase <= last_next;
            addr_par_err <= aerr_next;
            data_par_err <= derr_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_par_lags_ad: assert property (@(posedge sys_clk) disable iff (!resetn)
        $fell(ad_oe) |-> primary_parity_line_oe ##1 !primary_parity_line_oe)
        else $error("parity released with data lines");
    a_par_even: assert property (@(posedge sys_clk) disable iff (!resetn)
        primary_parity_line_oe && $past(ad_oe) |->
        ^{$past(ad_out), $past(par_cbe), primary_parity_line_out} == 1'b0)
        else $error("driven parity not even");
    a_trdy_high_release: assert property (@(posedge sys_clk) disable iff (!resetn)
        $fell(primary_target_ready_n_oe) |->
        $past(primary_target_ready_n_out) && !$past(primary_target_ready_n_out, 2))
        else $error("ready not high for exactly one clock before float");
    a_park_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
        parked && st_reg == ppp_pkg::PPP_IDLE && !(!frame_s && frame_d_reg) |=> ad_oe)
        else $error("granted idle bus not driven");
    a_trdy_held: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_reg == ppp_pkg::PPP_DATA && !primary_target_ready_n_out && !fire
        |=> !primary_target_ready_n_out)
        else $error("target ready dropped early");
    a_done_both: assert property (@(posedge sys_clk) disable iff (!resetn)
        xfer_done |-> $past(fire) && $past(st_reg == ppp_pkg::PPP_DATA))
        else $error("word moved without both readies");
    a_addr_sample: assert property (@(posedge sys_clk) disable iff (!resetn)
        st_reg == ppp_pkg::PPP_ADDR |-> addr_captured == $past(ad_s))
        else $error("address not sampled at frame start");
    a_apar_check: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(addr_valid) |-> addr_par_err == ^{$past(addr_captured, 1),
        $past(cmd_captured, 1), $past(par_s)})
        else $error("address parity check wrong");
    a_last_frame: assert property (@(posedge sys_clk) disable iff (!resetn)
        last_phase |-> xfer_done && $past(frame_s))
        else $error("last phase flagged without a word");
    c_read: cover property (@(posedge sys_clk) xfer_done && is_read_reg);
    c_write: cover property (@(posedge sys_clk) xfer_done && !is_read_reg);
    c_park: cover property (@(posedge sys_clk) parked ##1 ad_oe);
    c_last: cover property (@(posedge sys_clk) last_phase);
endmodule

// ### test/ppp_initiator_model.sv
// Behavioural initiator on the primary bus: frame, initiator ready, AD, C/BE, parity.
// Assumes the bench resolves the shared lines and calls run() only while grant is high.
`timescale 1ns/1ps
module ppp_initiator_model (
    input wire logic sys_clk,
    input wire logic [31:0] ad_bus,
    input wire logic par_bus,
    input wire logic trdy_n_bus,
    output logic frame_n,
    output logic irdy_n,
    output logic [31:0] ad,
    output logic [3:0] cbe,
    output logic par,
    output logic ad_oe,
    output logic cbe_oe,
    output logic par_oe
);
    // ------------------------------------------------------------
    // Single-word transfer
    // ------------------------------------------------------------
    initial begin
        {frame_n, irdy_n, ad_oe, cbe_oe, par_oe} = 5'h18;
        {ad, cbe, par} = '0;
    end

    // Gives up after 40 clocks, which is how a refused claim shows
    task automatic run(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] be, input logic [1:0] bad, output logic ok,
                       output logic [31:0] rd, output logic rd_par);
        int n;
        logic [3:0] cmd;
        cmd = {3'h3, wr};
        @(posedge sys_clk);
        frame_n <= 1'b0;
        ad <= a;
        cbe <= cmd;
        {ad_oe, cbe_oe} <= 2'h3;
        @(posedge sys_clk);
        frame_n <= 1'b1;
        irdy_n <= 1'b0;
        par <= ^{a, cmd} ^ bad[0];
        par_oe <= 1'b1;
        cbe <= be;
        ad <= d;
        ad_oe <= wr;
        @(posedge sys_clk);
        if (wr) par <= ^{d, be} ^ bad[1];
        else par_oe <= 1'b0;
        n = 0;
        while (trdy_n_bus !== 1'b0 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        ok = (n < 40);
        rd = ad_bus;
        irdy_n <= 1'b1;
        {ad_oe, cbe_oe} <= 2'h0;
        @(posedge sys_clk);
        rd_par = par_bus;
        par_oe <= 1'b0;
    endtask
endmodule

// ### test/ppp_port_test.sv
// Self-checking bench for the primary port: a table of transfers, then parking,
// wait states and a refused claim. Assumes the initiator model of test/.
`timescale 1ns/1ps
module pci_primary_port_signaling_test;
    typedef struct packed {
        logic wr;
        logic [31:0] a;
        logic [31:0] d;
        logic [3:0] be;
        logic [1:0] bad;
    } ppp_row_t;
    logic sys_clk, resetn, grant_n, core_claim, core_ready, clr, ok, rd_par;
    logic [31:0] core_rd_data, ad_out, ad_bus, ad_last, m_ad, addr_captured, wr_data, rd;
    logic [3:0] cbe_out, cbe_bus, cbe_last, m_cbe, cmd_captured, wr_byte_en;
    logic ad_oe, cbe_oe, par_out, par_oe, par_bus, par_last, m_par, m_ad_oe, m_cbe_oe;
    logic m_par_oe, frame_n, irdy_n, trdy_out, trdy_oe, trdy_bus, trdy_d, trdy_oe_d, ad_oe_d;
    logic addr_valid, xfer_done, last_phase, addr_par_err, data_par_err;
    int failures, n_tests, n_xfer, n_last, n_aerr, n_derr, n_aval;
    logic trdy_d2;
    ppp_row_t rows [4];

    // ------------------------------------------------------------
    // Shared lines: an undriven AD, C/BE or parity line shows the inverse of its last value; target ready idles high
    // ------------------------------------------------------------
    assign ad_bus = ad_oe ? ad_out : m_ad_oe ? m_ad : ~ad_last;
    assign cbe_bus = cbe_oe ? cbe_out : m_cbe_oe ? m_cbe : ~cbe_last;
    assign par_bus = par_oe ? par_out : m_par_oe ? m_par : ~par_last;
    assign trdy_bus = trdy_oe ? trdy_out : 1'b1;

    ppp_port uut (.sys_clk(sys_clk), .resetn(resetn), .ad_in(ad_bus), .ad_out(ad_out),
        .ad_oe(ad_oe), .primary_cmd_byte_en_lines_in(cbe_bus),
        .primary_cmd_byte_en_lines_out(cbe_out), .primary_cmd_byte_en_lines_oe(cbe_oe),
        .primary_parity_line_in(par_bus), .primary_parity_line_out(par_out),
        .primary_parity_line_oe(par_oe), .frame_n_in(frame_n),
        .primary_initiator_ready_n_in(irdy_n), .primary_target_ready_n_in(trdy_bus),
        .primary_target_ready_n_out(trdy_out), .primary_target_ready_n_oe(trdy_oe),
        .grant_n(grant_n), .core_claim(core_claim), .core_ready(core_ready),
        .core_rd_data(core_rd_data), .addr_captured(addr_captured),
        .cmd_captured(cmd_captured), .addr_valid(addr_valid), .wr_data(wr_data),
        .wr_byte_en(wr_byte_en), .xfer_done(xfer_done), .last_phase(last_phase),
        .addr_par_err(addr_par_err), .data_par_err(data_par_err));

    ppp_initiator_model ini (.sys_clk(sys_clk), .ad_bus(ad_bus), .par_bus(par_bus),
        .trdy_n_bus(trdy_bus), .frame_n(frame_n), .irdy_n(irdy_n), .ad(m_ad), .cbe(m_cbe),
        .par(m_par), .ad_oe(m_ad_oe), .cbe_oe(m_cbe_oe), .par_oe(m_par_oe));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task summarize;
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        ad_last <= ad_bus;
        cbe_last <= cbe_bus;
        par_last <= par_bus;
        trdy_d <= trdy_out;
        trdy_d2 <= trdy_d;
        n_aval <= clr ? 0 : n_aval + addr_valid;
        trdy_oe_d <= trdy_oe;
        ad_oe_d <= ad_oe;
        n_xfer <= clr ? 0 : n_xfer + xfer_done;
        n_last <= clr ? 0 : n_last + last_phase;
        n_aerr <= clr ? 0 : n_aerr + addr_par_err;
        n_derr <= clr ? 0 : n_derr + data_par_err;
        if (resetn && trdy_oe_d && !trdy_oe) chk({trdy_d2, trdy_d}, 32'h1);
        if (resetn && ad_oe_d && !ad_oe) chk(par_oe, 32'h1);
        if ((ad_oe && m_ad_oe) || (cbe_oe && m_cbe_oe) || (par_oe && m_par_oe))
            chk(32'h1, 32'h0);
    end

    initial begin
        #100000;
        failures++;
        summarize();
    end

    initial begin
        {ad_last, cbe_last, par_last} = '0;
        {resetn, grant_n, core_claim, core_ready, clr} = 5'h0F;
        core_rd_data = 32'h0;
        failures = 0;
        n_tests = 0;
        rows = '{'{1'b1, 32'h0000_1000, 32'hA5A5_5A5A, 4'hF, 2'h0},
                 '{1'b0, 32'h0000_2004, 32'h1234_5678, 4'h3, 2'h0},
                 '{1'b1, 32'hFFFF_FFFC, 32'hFFFF_FFFF, 4'h0, 2'h2},
                 '{1'b0, 32'h8000_0000, 32'h0000_0001, 4'h8, 2'h1}};
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        foreach (rows[i]) begin
            clr <= 1'b1;
            core_rd_data <= rows[i].d;
            @(posedge sys_clk);
            clr <= 1'b0;
            ini.run(rows[i].wr, rows[i].a, rows[i].d, rows[i].be, rows[i].bad, ok, rd, rd_par);
            repeat (6) @(posedge sys_clk);
            chk(ok, 32'h1);
            chk(addr_captured, rows[i].a);
            chk(cmd_captured, {3'h3, rows[i].wr});
            chk(n_xfer, 32'h1);
            chk(n_last, 32'h1);
            chk(n_aval, 32'h1);
            chk(n_aerr > 0, rows[i].bad[0]);
            chk(n_derr > 0, rows[i].wr & rows[i].bad[1]);
            if (rows[i].wr) begin
                chk(wr_data, rows[i].d);
                chk(wr_byte_en, rows[i].be);
            end else begin
                chk(rd, rows[i].d);
                chk(rd_par, ^{rows[i].d, rows[i].be});
            end
        end
        // Parking while idle, then release when the grant goes away
        grant_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({ad_oe, cbe_oe, par_oe}, 3'h7);
        chk(^{ad_bus, cbe_bus, par_bus}, 32'h0);
        grant_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk({ad_oe, cbe_oe, par_oe}, 3'h0);
        // Wait states: target ready must not come before the core is ready
        core_ready <= 1'b0;
        clr <= 1'b1;
        core_rd_data <= 32'h0F0F_F0F0;
        @(posedge sys_clk);
        clr <= 1'b0;
        fork
            ini.run(1'b0, 32'h0000_3000, 32'h0, 4'h5, 2'h0, ok, rd, rd_par);
            begin
                repeat (14) @(posedge sys_clk);
                chk(trdy_bus, 32'h1);
                chk(n_xfer, 32'h0);
                core_ready <= 1'b1;
            end
        join
        chk(rd, 32'h0F0F_F0F0);
        chk(rd_par, ^{32'h0F0F_F0F0, 4'h5});
        // Refused claim: no word may move; let the last transfer close first
        repeat (6) @(posedge sys_clk);
        core_claim <= 1'b0;
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        ini.run(1'b1, 32'h0000_4000, 32'h1, 4'hF, 2'h0, ok, rd, rd_par);
        chk(ok, 32'h0);
        chk(n_xfer, 32'h0);
        chk(n_aval, 32'h1);
        // Reset while parked: everything floats, then parking resumes
        grant_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({ad_oe, cbe_oe, par_oe, trdy_oe, trdy_out}, 32'h1);
        chk(addr_captured, 32'h0);
        resetn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk({ad_oe, cbe_oe, par_oe}, 3'h7);
        summarize();
    end
endmodule
